// >>> pfg_port_four.sv
// seven-pin gpio port with mode fields, pull-ups and four edge interrupts
//
// Function
// (R1) seven pins, data register at F4h
// (R2) reset clears mode registers, pins input
// (R3) low pins: falling, rising or both edges
// (R4) bits 5:4 choose seventh pin mode
// (R5) bits 3:2 choose sixth pin mode
// (R6) bits 1:0 choose fifth pin mode
// (R7) software also enables function in peripheral
// (R8) edge field: off, fall, rise, both
// (R9) edge register holds four two-bit fields
// (R10) edge sets pending, request line low
// (R11) writing 0 clears pending bit
// (R12) pending at F7h, bits 3:0, reset zero
// (R13) pending readable at any time
// (R14) pull-up register at F5h, per pin
// (R15) pull-up off for output or alternate
// (R16) low pins carry interrupts, share lcd
// (R17) two-flop sync, edge from successive samples
// (R18) edge beats simultaneous clear of pending
`timescale 1ns/1ps
module pfg_port_four #(
    parameter int PINS = pfg_pkg::PFG_PINS,
    parameter int LOW_PINS = pfg_pkg::PFG_LOW_PINS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pfg_pkg::pfg_reg_req_t regReq,
    output logic [pfg_pkg::PFG_DATA_W-1:0] regRdData,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    output logic [PINS-1:0] pullupOn,
    input wire logic [PINS-1:0] lcdSegmentDrive,
    input wire logic timer16BMatchOut,
    input wire logic timer16BPwmOut,
    output logic timer16AExtClock,
    output logic timer16BExtClock,
    output logic timer16BCaptureIn,
    output logic irqReqN
);
    import pfg_pkg::*;

    pfg_state_t st;
    pfg_state_t next_st;

    // per-pin decode of the mode fields
    logic [2*PINS-1:0] pinFld;
    logic [PINS-1:0] pinIsIn;
    logic [PINS-1:0] drvOe;
    logic [PINS-1:0] drvOut;
    logic [PINS-1:0] pinRead;
    logic [LOW_PINS-1:0] riseEdge;
    logic [LOW_PINS-1:0] fallEdge;
    logic [LOW_PINS-1:0] edgeHit;
    logic [LOW_PINS-1:0] pendClr;
    logic timerBDrive;
    logic wrPending;

    // the timer runs one output mode at a time, inactive output low
    assign timerBDrive = timer16BMatchOut | timer16BPwmOut;
    assign wrPending = regReq.wrEn && (regReq.addr == PFG_ADDR_PENDING);

    // one slice per pin: mode field, drive and pull-up decision
    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
        // only the sixth pin has a timer output; low pins use alt as lcd
        localparam bit ALT_OK = (i == PFG_PIN_TMR_B_CAP) || (i < LOW_PINS);
        localparam bit ALT_TMR = (i == PFG_PIN_TMR_B_CAP);
        if (i < LOW_PINS)
        begin : g_low
            assign pinFld[2*i +: 2] = st.lowerMode[2*i +: 2];
        end
        else
        begin : g_up
            // fields at 1:0, 3:2, 5:4 for the fifth, sixth, seventh pin
            assign pinFld[2*i +: 2] = st.upperMode[2*(i-LOW_PINS) +: 2]; // [R4] [R5] [R6]
        end
        assign pinIsIn[i] = (pinFld[2*i +: 2] == PFG_MODE_INPUT);
        // not-available codes leave the pin undriven
        assign drvOe[i] = (pinFld[2*i +: 2] == PFG_MODE_OUTPUT)
            || (pinFld[2*i +: 2] == PFG_MODE_LCD)
            || ((pinFld[2*i +: 2] == PFG_MODE_ALT) && ALT_OK); // [R4] [R5] [R6] [R16]
        assign drvOut[i] = (pinFld[2*i +: 2] == PFG_MODE_OUTPUT) ? st.dataLatch[i]
            : ((pinFld[2*i +: 2] == PFG_MODE_ALT) && ALT_TMR) ? timerBDrive
            : lcdSegmentDrive[i]; // [R5] [R16]
        // output pins read back the latch, others the synchronised pin
        assign pinRead[i] = (pinFld[2*i +: 2] == PFG_MODE_OUTPUT) ? st.dataLatch[i]
            : st.sync2[i]; // [R1]
    end

    // edge detect on the low pins, only while they are inputs
    for (genvar j = 0; j < LOW_PINS; j++)
    begin : g_irq
        assign riseEdge[j] = st.sync2[j] & ~st.prevLow[j]; // [R17]
        assign fallEdge[j] = ~st.sync2[j] & st.prevLow[j]; // [R17]
        always_comb
        begin
            unique case (pfg_edge_t'(st.edgeEn[2*j +: 2])) // [R8] [R9]
                PFG_EDGE_OFF: edgeHit[j] = 1'b0;
                PFG_EDGE_FALL: edgeHit[j] = fallEdge[j] & pinIsIn[j];
                PFG_EDGE_RISE: edgeHit[j] = riseEdge[j] & pinIsIn[j];
                PFG_EDGE_BOTH: edgeHit[j] = (riseEdge[j] | fallEdge[j]) & pinIsIn[j]; // [R3]
            endcase
        end
        assign pendClr[j] = wrPending && !regReq.wrData[j]; // [R11]
    end

    // next state of the whole port
    always_comb
    begin
        next_st = st;
        // two-flop synchroniser, third stage holds the previous sample
        next_st.sync1 = pinIn; // [R17]
        next_st.sync2 = st.sync1; // [R17]
        next_st.prevLow = st.sync2[LOW_PINS-1:0]; // [R17]

        // register writes
        if (regReq.wrEn)
        begin
            unique case (regReq.addr)
                PFG_ADDR_DATA: next_st.dataLatch = regReq.wrData[PINS-1:0]; // [R1]
                PFG_ADDR_PULLUP: next_st.pullupEn = regReq.wrData; // [R14]
                PFG_ADDR_EDGE_EN: next_st.edgeEn = regReq.wrData; // [R9]
                PFG_ADDR_UPPER_MODE:
                    next_st.upperMode = regReq.wrData[PFG_UPPER_MODE_W-1:0]; // [R4]
                PFG_ADDR_LOWER_MODE: next_st.lowerMode = regReq.wrData;
                default: next_st.dataLatch = st.dataLatch;
            endcase
        end

        // write 0 clears, write 1 leaves alone; a new edge wins
        next_st.pending = (st.pending & ~pendClr) | edgeHit; // [R10] [R11] [R18]
        next_st.irqReqN = ~|next_st.pending; // [R10]

        // pin drivers; pull-up only in plain input mode
        next_st.pinOe = drvOe;
        next_st.pinOut = drvOut;
        next_st.pullupOn = st.pullupEn[PINS-1:0] & pinIsIn; // [R15]

        // peripheral inputs follow the pin only in input mode
        next_st.tmrAClk = st.sync2[PFG_PIN_TMR_A_CLK] & pinIsIn[PFG_PIN_TMR_A_CLK]; // [R6]
        next_st.tmrBCap = st.sync2[PFG_PIN_TMR_B_CAP] & pinIsIn[PFG_PIN_TMR_B_CAP]; // [R5]
        next_st.tmrBClk = st.sync2[PFG_PIN_TMR_B_CLK] & pinIsIn[PFG_PIN_TMR_B_CLK]; // [R4]

        // reads answer one cycle later and hold until the next read
        if (regReq.rdEn)
        begin
            unique case (regReq.addr)
                PFG_ADDR_DATA: next_st.rdData = {1'b0, pinRead}; // [R1]
                PFG_ADDR_PULLUP: next_st.rdData = st.pullupEn; // [R14]
                PFG_ADDR_EDGE_EN: next_st.rdData = st.edgeEn;
                PFG_ADDR_PENDING: next_st.rdData = {4'h0, st.pending}; // [R12] [R13]
                PFG_ADDR_UPPER_MODE: next_st.rdData = {2'h0, st.upperMode};
                PFG_ADDR_LOWER_MODE: next_st.rdData = st.lowerMode;
                default: next_st.rdData = 8'h00;
            endcase
        end
    end

    // the only clocked process; reset loads constants only
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.dataLatch <= PFG_RST_DATA;
            st.pullupEn <= PFG_RST_PULLUP; // [R14]
            st.edgeEn <= PFG_RST_EDGE_EN;
            st.pending <= PFG_RST_PENDING; // [R12]
            st.upperMode <= PFG_RST_UPPER_MODE; // [R2]
            st.lowerMode <= PFG_RST_LOWER_MODE; // [R2]
            st.irqReqN <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign regRdData = st.rdData;
    assign pinOut = st.pinOut;
    assign pinOe = st.pinOe;
    assign pullupOn = st.pullupOn;
    assign timer16AExtClock = st.tmrAClk;
    assign timer16BExtClock = st.tmrBClk;
    assign timer16BCaptureIn = st.tmrBCap;
    assign irqReqN = st.irqReqN;

    // a qualifying edge shows in the pending bits on the next edge
    pend_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        (edgeHit != 4'h0) |=> ((st.pending & $past(edgeHit)) == $past(edgeHit)))
        else $error("edge did not set pending bit");

    // request line goes low with any new pending bit
    irq_low_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        (edgeHit != 4'h0) |=> !irqReqN)
        else $error("request line not low after edge");

    // zero write without edge clears the bit
    pend_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
        (wrPending && !regReq.wrData[0] && !edgeHit[0]) |=> !st.pending[0])
        else $error("pending bit not cleared by zero write");

    // edge in the clearing cycle keeps the bit
    set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R18]
        (wrPending && !regReq.wrData[1] && edgeHit[1]) |=> st.pending[1])
        else $error("edge lost against clear");

    // disabled field never raises a bit
    edge_off_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
        (st.edgeEn[1:0] == 2'b00 && !st.pending[0]) |=> !st.pending[0])
        else $error("disabled input raised pending");

    // pull-up never on while the pin is driven
    pull_off_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
        pinOe != 7'h00 |-> ((pinOe & pullupOn) == 7'h00))
        else $error("pull-up on at a driven pin");

    // seventh pin in output mode drives the latch
    pin6_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        ($past(st.upperMode[5:4]) == 2'b01) |-> (pinOe[6] && pinOut[6] == $past(st.dataLatch[6])))
        else $error("seventh pin output mode wrong");

    // sixth pin alternate mode carries the timer output
    pin5_tmr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        ($past(st.upperMode[3:2]) == 2'b10) |-> (pinOe[5] && pinOut[5] == $past(timerBDrive)))
        else $error("sixth pin timer output wrong");

    // fifth pin not-available code leaves it floating
    pin4_na_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        ($past(st.upperMode[1:0]) == 2'b10) |-> !pinOe[4])
        else $error("fifth pin driven in unavailable mode");

    // pending read shows the bits, upper nibble zero
    pend_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12] [R13]
        (regReq.rdEn && regReq.addr == PFG_ADDR_PENDING)
        |=> (regRdData == {4'h0, $past(st.pending)}))
        else $error("pending read value wrong");

    // a pin edge reaches the pending bit within the sync delay
    sync_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
        (st.edgeEn[1:0] == 2'b11 && pinIsIn[0] && !st.pending[0] && !wrPending
         && $rose(st.sync1[0]) && !st.prevLow[0] && !st.sync2[0]) ##1
        (st.edgeEn[1:0] == 2'b11 && pinIsIn[0]) |=> st.pending[0])
        else $error("synchronised edge missed");

    // a one write leaves a set pending bit alone
    pend_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
        (st.pending[2] && !(wrPending && !regReq.wrData[2])) |=> st.pending[2])
        else $error("pending bit lost without zero write");

    // request line mirrors the pending bits
    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        irqReqN == (st.pending == 4'h0))
        else $error("request line disagrees with pending");

    // falling-only field ignores a rise
    fall_only_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
        (st.edgeEn[1:0] == 2'b01 && riseEdge[0]) |-> !edgeHit[0])
        else $error("falling field took a rise");

    // rising-only field ignores a fall
    rise_only_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
        (st.edgeEn[3:2] == 2'b10 && fallEdge[1]) |-> !edgeHit[1])
        else $error("rising field took a fall");

    // both-edges field takes either edge
    both_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        (st.edgeEn[5:4] == 2'b11 && pinIsIn[2] && (riseEdge[2] || fallEdge[2])) |-> edgeHit[2])
        else $error("both-edge field missed an edge");

    // a pin that is not an input never raises an edge
    mode_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
        !pinIsIn[3] |-> !edgeHit[3])
        else $error("edge taken on a non-input pin");

    // data write lands in the latch
    data_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        (regReq.wrEn && regReq.addr == PFG_ADDR_DATA)
        |=> (st.dataLatch == $past(regReq.wrData[6:0])))
        else $error("data write lost");

    // pull-up write lands in the enable register
    pull_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
        (regReq.wrEn && regReq.addr == PFG_ADDR_PULLUP) |=> (st.pullupEn == $past(regReq.wrData)))
        else $error("pull-up write lost");

    // edge enable write lands in the field register
    edge_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
        (regReq.wrEn && regReq.addr == PFG_ADDR_EDGE_EN) |=> (st.edgeEn == $past(regReq.wrData)))
        else $error("edge enable write lost");

    // upper mode write keeps six bits
    upper_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (regReq.wrEn && regReq.addr == PFG_ADDR_UPPER_MODE)
        |=> (st.upperMode == $past(regReq.wrData[5:0])))
        else $error("upper mode write lost");

    // enabled pull-up follows an input pin
    pull_input_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14] [R15]
        (pinIsIn[0] && st.pullupEn[0]) |=> pullupOn[0])
        else $error("pull-up missing on input pin");

    // fifth pin in input mode feeds the timer clock
    tmr_a_in_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        (st.upperMode[1:0] == 2'b00) |=> (timer16AExtClock == $past(st.sync2[4])))
        else $error("timer clock not following fifth pin");

    // fifth pin not in input mode holds the timer clock low
    pin4_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        (st.upperMode[1:0] != 2'b00) |=> !timer16AExtClock)
        else $error("timer clock leaks from fifth pin");

    // sixth pin not in input mode holds the capture low
    pin5_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
        (st.upperMode[3:2] != 2'b00) |=> !timer16BCaptureIn)
        else $error("capture leaks from sixth pin");

    // seventh pin not in input mode holds the timer clock low
    pin6_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (st.upperMode[5:4] != 2'b00) |=> !timer16BExtClock)
        else $error("timer clock leaks from seventh pin");

    // seventh pin segment mode drives the lcd level
    pin6_lcd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4] [R16]
        (st.upperMode[5:4] == 2'b11) |=> (pinOe[6] && pinOut[6] == $past(lcdSegmentDrive[6])))
        else $error("seventh pin segment drive wrong");

    // low pin segment mode drives the lcd level
    lcd_low_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
        (st.lowerMode[5:4] == 2'b11) |=> (pinOe[2] && pinOut[2] == $past(lcdSegmentDrive[2])))
        else $error("low pin segment drive wrong");

    // data read has bit 7 clear
    data_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        (regReq.rdEn && regReq.addr == PFG_ADDR_DATA) |=> !regRdData[7])
        else $error("data read bit 7 set");

    // upper mode read has reserved bits clear
    upper_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
        (regReq.rdEn && regReq.addr == PFG_ADDR_UPPER_MODE) |=> (regRdData[7:6] == 2'b00))
        else $error("upper mode reserved bits set");

    // read data holds between reads so a slow poll still sees it
    rd_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
        !regReq.rdEn |=> $stable(regRdData))
        else $error("read data changed without a read");

endmodule

// >>> pfg_pkg.sv
// shared constants and types for the seven-pin port with external interrupts
package pfg_pkg;

    // pin counts and register data width
    localparam int PFG_PINS = 7;
    localparam int PFG_LOW_PINS = 4;
    localparam int PFG_DATA_W = 8;

    // register byte addresses on the cpu register bus
    localparam logic [7:0] PFG_ADDR_DATA = 8'hF4;
    localparam logic [7:0] PFG_ADDR_PULLUP = 8'hF5;
    localparam logic [7:0] PFG_ADDR_EDGE_EN = 8'hF6;
    localparam logic [7:0] PFG_ADDR_PENDING = 8'hF7;
    localparam logic [7:0] PFG_ADDR_UPPER_MODE = 8'hF8;
    localparam logic [7:0] PFG_ADDR_LOWER_MODE = 8'hF9;

    // reset values
    localparam logic [7:0] PFG_RST_PULLUP = 8'h00;
    localparam logic [7:0] PFG_RST_EDGE_EN = 8'h00;
    localparam logic [3:0] PFG_RST_PENDING = 4'h0;
    localparam logic [5:0] PFG_RST_UPPER_MODE = 6'h00;
    localparam logic [7:0] PFG_RST_LOWER_MODE = 8'h00;
    localparam logic [6:0] PFG_RST_DATA = 7'h00;

    // field layout
    localparam int PFG_FIELD_W = 2;
    localparam int PFG_UPPER_MODE_W = 6;
    localparam int PFG_PENDING_W = 4;
    localparam int PFG_PIN_TMR_A_CLK = 4;
    localparam int PFG_PIN_TMR_B_CAP = 5;
    localparam int PFG_PIN_TMR_B_CLK = 6;

    // two-bit pin mode field
    typedef enum logic [1:0] {
        PFG_MODE_INPUT = 2'b00,
        PFG_MODE_OUTPUT = 2'b01,
        PFG_MODE_ALT = 2'b10,
        PFG_MODE_LCD = 2'b11
    } pfg_mode_t;

    // two-bit external interrupt edge field
    typedef enum logic [1:0] {
        PFG_EDGE_OFF = 2'b00,
        PFG_EDGE_FALL = 2'b01,
        PFG_EDGE_RISE = 2'b10,
        PFG_EDGE_BOTH = 2'b11
    } pfg_edge_t;

    // one register bus request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pfg_reg_req_t;

    // all state of the port
    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [3:0] prevLow;
        logic [6:0] dataLatch;
        logic [7:0] pullupEn;
        logic [7:0] edgeEn;
        logic [3:0] pending;
        logic [5:0] upperMode;
        logic [7:0] lowerMode;
        logic [6:0] pinOut;
        logic [6:0] pinOe;
        logic [6:0] pullupOn;
        logic tmrAClk;
        logic tmrBClk;
        logic tmrBCap;
        logic irqReqN;
        logic [7:0] rdData;
    } pfg_state_t;

endpackage

// >>> pfg_pad_model.sv
// pads, timer and lcd drivers outside the seven-pin port
`timescale 1ns/1ps
module pfg_pad_model (
    input wire logic core_clk,
    input wire logic [6:0] pinOut,
    input wire logic [6:0] pinOe,
    input wire logic [6:0] pullupOn,
    input wire logic [6:0] extDrive,
    input wire logic [6:0] extLevel,
    input wire logic tmrEn,
    input wire logic [6:0] lcdLevel,
    output logic [6:0] pinIn,
    output logic [6:0] lcdSegmentDrive,
    output logic timer16BMatchOut,
    output logic timer16BPwmOut
);
    logic [6:0] floatPat = 7'h55;
    // a floating pad has no defined level, so it flips every cycle
    always @(posedge core_clk)
        floatPat <= ~floatPat;
    // port drive wins, then the outside world, then the pull-up
    always_comb
        for (int i = 0; i < 7; i++)
            pinIn[i] = pinOe[i] ? pinOut[i] : extDrive[i] ? extLevel[i] :
                pullupOn[i] ? 1'b1 : floatPat[i];
    // the timer drives only once enabled inside itself, low otherwise
    assign timer16BMatchOut = tmrEn;
    assign timer16BPwmOut = 1'b0;
    assign lcdSegmentDrive = lcdLevel;
endmodule

// >>> tb_top.sv
// self-checking bench for the seven-pin port with edge interrupts
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import pfg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    pfg_reg_req_t regReq = '0;
    logic [7:0] regRdData;
    logic [6:0] pinIn, pinOut, pinOe, pullupOn, lcdSegmentDrive;
    logic [6:0] extDrive = 7'h7F;
    logic [6:0] extLevel = 7'h00;
    logic [6:0] lcdLevel = 7'h2A;
    logic tmrEn = 1'b0;
    logic matchOut, pwmOut, tmrAClk, tmrBClk, tmrBCap, irqReqN;
    logic [15:0] seed = 16'h1238;
    int error_cnt = 0;
    int compares = 0;
    pfg_port_four u_dut (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
        .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .lcdSegmentDrive(lcdSegmentDrive),
        .timer16BMatchOut(matchOut), .timer16BPwmOut(pwmOut),
        .timer16AExtClock(tmrAClk), .timer16BExtClock(tmrBClk),
        .timer16BCaptureIn(tmrBCap), .irqReqN(irqReqN));
    pfg_pad_model u_pad (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .extDrive(extDrive), .extLevel(extLevel), .tmrEn(tmrEn),
        .lcdLevel(lcdLevel), .pinIn(pinIn), .lcdSegmentDrive(lcdSegmentDrive),
        .timer16BMatchOut(matchOut), .timer16BPwmOut(pwmOut));
    initial
        forever #5 core_clk = ~core_clk;
    // random source, repeatable from a fixed start
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // which edge an edge code accepts
    function automatic logic expPend(input int code, input logic rising);
        return rising ? code[1] : code[0];
    endfunction
    // bus cycles: called at a falling edge, taken at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq.wrEn = 1'b1;
        regReq.addr = a;
        regReq.wrData = d;
        @(negedge core_clk);
        regReq.wrEn = 1'b0;
        // idle cycle so back-to-back calls never re-raise the strobe in one step
        @(negedge core_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        regReq.rdEn = 1'b1;
        regReq.addr = a;
        @(negedge core_clk);
        regReq.rdEn = 1'b0;
        `CHK($sformatf("reg %h", a), ex, regRdData)
        @(negedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (50000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        for (int a = 8'hF5; a <= 8'hF9; a++)
            rd_chk(8'(a), 8'h00);
        rd_chk(8'hF3, 8'h00);
        `CHK("irq line", 1'b1, irqReqN)
        `CHK("pad enable", 7'h00, pinOe)
        $display("test reset done");
        // random readback with an unmapped write in between
        repeat (8)
        begin
            seed = lfsr(seed);
            wr(PFG_ADDR_PULLUP, seed[7:0]);
            wr(PFG_ADDR_EDGE_EN, seed[15:8]);
            wr(PFG_ADDR_UPPER_MODE, seed[7:0]);
            wr(8'hF3, 8'hFF);
            rd_chk(PFG_ADDR_PULLUP, seed[7:0]);
            rd_chk(PFG_ADDR_EDGE_EN, seed[15:8]);
            rd_chk(PFG_ADDR_UPPER_MODE, {2'b00, seed[5:0]});
        end
        $display("test readback done");
        // all pins output: pull-ups forced off whatever the enables say
        wr(PFG_ADDR_EDGE_EN, 8'h00);
        wr(PFG_ADDR_PULLUP, 8'hFF);
        wr(PFG_ADDR_LOWER_MODE, 8'h55);
        wr(PFG_ADDR_UPPER_MODE, 8'h15);
        wr(PFG_ADDR_DATA, seed[7:0]);
        repeat (2) @(negedge core_clk);
        `CHK("pad enable", 7'h7F, pinOe)
        `CHK("pad level", seed[6:0], pinOut)
        `CHK("pull-up", 7'h00, pullupOn)
        rd_chk(PFG_ADDR_DATA, {1'b0, seed[6:0]});
        // timer pin, lcd pin and a plain input among the upper pins
        tmrEn = 1'b1;
        extLevel[6:4] = 3'b111;
        wr(PFG_ADDR_UPPER_MODE, 8'h38);
        repeat (4) @(negedge core_clk);
        `CHK("timer pin", 2'b11, {pinOe[5], pinOut[5]})
        `CHK("lcd pin", {1'b1, lcdLevel[6]}, {pinOe[6], pinOut[6]})
        `CHK("upper pull-up", 3'b001, pullupOn[6:4])
        `CHK("timer inputs", 3'b100, {tmrAClk, tmrBClk, tmrBCap})
        wr(PFG_ADDR_UPPER_MODE, 8'h00);
        repeat (4) @(negedge core_clk);
        `CHK("timer inputs", 3'b111, {tmrAClk, tmrBClk, tmrBCap})
        // undriven inputs read high through their pull-ups
        wr(PFG_ADDR_LOWER_MODE, 8'h00);
        extDrive = 7'h00;
        repeat (4) @(negedge core_clk);
        `CHK("pull-up", 7'h7F, pullupOn)
        rd_chk(PFG_ADDR_DATA, 8'h7F);
        extDrive = 7'h7F;
        extLevel = 7'h00;
        wr(PFG_ADDR_PULLUP, 8'h00);
        repeat (4) @(negedge core_clk);
        $display("test modes done");
        // every edge code on every low pin, both directions
        for (int j = 0; j < 4; j++)
            for (int c = 0; c < 4; c++)
            begin
                wr(PFG_ADDR_EDGE_EN, 8'(c << (2 * j)));
                extLevel[j] = 1'b1;
                repeat (2) @(negedge core_clk);
                `CHK("irq early", 1'b1, irqReqN)
                @(negedge core_clk);
                rd_chk(PFG_ADDR_PENDING, {7'h00, expPend(c, 1'b1)} << j);
                `CHK("irq line", ~expPend(c, 1'b1), irqReqN)
                wr(PFG_ADDR_PENDING, 8'h00);
                extLevel[j] = 1'b0;
                repeat (3) @(negedge core_clk);
                rd_chk(PFG_ADDR_PENDING, {7'h00, expPend(c, 1'b0)} << j);
                wr(PFG_ADDR_PENDING, 8'h00);
                @(negedge core_clk);
                `CHK("irq released", 1'b1, irqReqN)
            end
        $display("test edges done");
        // clear in the very cycle a new edge lands keeps the bit
        wr(PFG_ADDR_EDGE_EN, 8'h01);
        extLevel[0] = 1'b1;
        repeat (4) @(negedge core_clk);
        extLevel[0] = 1'b0;
        repeat (2) @(negedge core_clk);
        wr(PFG_ADDR_PENDING, 8'h00);
        rd_chk(PFG_ADDR_PENDING, 8'h01);
        wr(PFG_ADDR_PENDING, 8'hFF);
        rd_chk(PFG_ADDR_PENDING, 8'h01);
        wr(PFG_ADDR_LOWER_MODE, 8'hF5);
        // second reset in mid-run with a request standing
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        `CHK("irq line", 1'b1, irqReqN)
        rd_chk(PFG_ADDR_PENDING, 8'h00);
        rd_chk(PFG_ADDR_LOWER_MODE, 8'h00);
        $display("test clear race done");
        report_and_stop();
    end
endmodule
